// File: rtl/ccc_pkg.sv
package ccc_pkg;

  // special function register addresses
  localparam logic [7:0] CCC_ADDR_MODE     = 8'hDB; // channel mode register
  localparam logic [7:0] CCC_ADDR_CMP_LOW  = 8'hFB; // compare value low byte
  localparam logic [7:0] CCC_ADDR_CMP_HIGH = 8'hFC; // compare value high byte

  // mode register field positions
  localparam int CCC_MODE_WIDE = 7; // wide pulse select
  localparam int CCC_MODE_CMP_EN = 6; // comparator function enable
  localparam int CCC_MODE_RISE = 5; // rising capture enable
  localparam int CCC_MODE_FALL = 4; // falling capture enable
  localparam int CCC_MODE_MATCH  = 3; // match flag enable
  localparam int CCC_MODE_TOGGLE = 2; // toggle output enable
  localparam int CCC_MODE_PWM  = 1; // pulse output enable
  localparam int CCC_MODE_IRQ  = 0; // flag interrupt enable

  // reset values
  localparam logic [7:0]  CCC_MODE_RST   = 8'h00; // mode register
  localparam logic [15:0] CCC_CMP_RST    = 16'h0000; // capture/compare pair
  localparam logic [15:0] CCC_RELOAD_RST = 16'h0000; // auto-reload pair
  localparam logic        CCC_PIN_RST    = 1'b0; // output pin level
  localparam logic [7:0]  CCC_RDATA_IDLE = 8'h00; // read data when idle or unmapped

  // counter width and narrow pulse widths
  localparam int          CCC_CNT_W      = 16; // counter array width
  localparam logic [1:0]  CCC_WIDTH_8    = 2'h0; // narrow width select for 8-bit
  localparam logic [15:0] CCC_MASK_FULL  = 16'hFFFF; // 16-bit compare mask
  localparam logic [15:0] CCC_MASK_BYTE  = 16'h00FF; // 8-bit compare mask
  localparam logic [15:0] CCC_MASK_9     = 16'h01FF; // 9-bit compare mask
  localparam logic [15:0] CCC_MASK_10    = 16'h03FF; // 10-bit compare mask
  localparam logic [15:0] CCC_MASK_11    = 16'h07FF; // 11-bit compare mask

  // output function chosen by the pulse and toggle bits
  typedef enum logic [1:0]
  {
    CCC_FN_IDLE   = 2'b00,
    CCC_FN_TOGGLE = 2'b01,
    CCC_FN_PWM    = 2'b10,
    CCC_FN_FREQ   = 2'b11
  } ccc_fn_type;

endpackage

// File: rtl/ccc_edge_sync.sv
`timescale 1ns/1ps

// brings the capture pin into the core clock and flags its edges
module ccc_edge_sync
(
  input  wire logic core_clk,  // core clock
  input  wire logic rst_b,     // synchronous reset, active low
  input  wire logic pin_in,    // raw capture pin
  output logic      rise,      // one-cycle pulse on rising edge
  output logic      fall       // one-cycle pulse on falling edge
);

  logic meta;  // first stage, read only by the second stage
  logic sync;  // second stage, safe level
  logic prev;  // previous safe level for edge detection

  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; pin is asynchronous to the core clock
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
    end
    else
    begin
      meta <= pin_in;
      sync <= meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge detect on the safe level only
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      prev <= 1'b0;
    else
      prev <= sync;
  end

  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

endmodule

// File: rtl/ccc_channel.sv
`timescale 1ns/1ps

// How it works
// - low address reaches compare value low byte
// - auto-reload select redirects low address to reload
// - writing low byte clears comparator enable
// - high address reaches high byte or reload
// - writing high byte sets comparator enable
// - bit 7 picks narrow or 16-bit pulse
// - bit 6 gates every compare based function
// - bit 5 enables capture on rising edge
// - bit 4 enables capture on falling edge
// - bit 3 sets event flag on match
// - bit 2 toggles output pin on match
// - toggle plus pulse gives frequency output
// - bit 1 drives pulse width modulated output
// - bit 0 passes event flag to interrupt
module ccc_channel
  import ccc_pkg::*;
(
  input  wire logic        core_clk,            // core clock, 100 MHz
  input  wire logic        rst_b,               // synchronous reset, active low
  input  wire logic [7:0]  sfr_addr,            // register address
  input  wire logic        sfr_wr,              // write strobe, one cycle
  input  wire logic        sfr_rd,              // read strobe, one cycle
  input  wire logic [7:0]  sfr_wdata,           // write data
  output logic      [7:0]  sfr_rdata,           // read data, valid the cycle after sfr_rd
  input  wire logic        auto_reload_select,  // steers byte addresses to reload value
  input  wire logic [1:0]  pulse_width_select,  // narrow width: 0..3 gives 8..11 bits
  input  wire logic [15:0] counter_value,       // counter array value
  input  wire logic        count_tick,          // counter advanced this cycle
  input  wire logic        capture_pin,         // asynchronous capture input
  input  wire logic        flag_clear,          // clears the event flag, one cycle
  output logic             channel1_event_flag, // capture/compare flag
  output logic             flag_irq,            // interrupt request level
  output logic             channel1_output_pin, // compare / pulse output
  output logic      [7:0]  channel1_mode        // mode register contents
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] cmp_value;   // capture/compare pair
  logic [15:0] reload;      // auto-reload pair for 9 to 11 bit pulses
  logic        cap_rise;    // synchronised rising edge
  logic        cap_fall;    // synchronised falling edge
  logic        cap_hit;     // enabled capture edge
  logic        wr_low;      // write to low byte address
  logic        wr_high;     // write to high byte address
  logic        cmp_en;      // comparator function enable
  logic [15:0] mask;        // active compare width
  logic        hit;         // counter equals compare value
  logic        wrap;        // counter rolled to zero in the active width
  logic        next_flag;   // flag value for the next cycle
  ccc_fn_type  fn;          // output function

  // mask for the active compare width
  function automatic logic [15:0] width_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    width_mask = CCC_MASK_BYTE;
      2'h1:    width_mask = CCC_MASK_9;
      2'h2:    width_mask = CCC_MASK_10;
      default: width_mask = CCC_MASK_11;
    endcase
  endfunction

  ccc_edge_sync u_edge
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   (capture_pin),
    .rise     (cap_rise),
    .fall     (cap_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode
  assign wr_low  = sfr_wr && (sfr_addr == CCC_ADDR_CMP_LOW);
  assign wr_high = sfr_wr && (sfr_addr == CCC_ADDR_CMP_HIGH);
  assign cmp_en  = channel1_mode[CCC_MODE_CMP_EN];
  assign fn      = ccc_fn_type'({channel1_mode[CCC_MODE_PWM], channel1_mode[CCC_MODE_TOGGLE]});
  assign cap_hit = (cap_rise && channel1_mode[CCC_MODE_RISE])
                || (cap_fall && channel1_mode[CCC_MODE_FALL]);

  // compare width: full word unless narrow pulse or frequency output
  always_comb
  begin
    if (fn == CCC_FN_FREQ)
      mask = CCC_MASK_BYTE;                      // frequency output compares low byte
    else if (fn == CCC_FN_PWM && !channel1_mode[CCC_MODE_WIDE])
      mask = width_mask(pulse_width_select);
    else
      mask = CCC_MASK_FULL;
  end

  // match and wrap only count on a counter step, else one value matches many cycles
  assign hit  = count_tick && ((counter_value & mask) == (cmp_value & mask));
  assign wrap = count_tick && ((counter_value & mask) == 16'h0000);

  //////////////////////////////////////////////////////////////////////////////
  // mode register; byte writes to the compare pair move the enable bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      channel1_mode <= CCC_MODE_RST;
    else if (sfr_wr && sfr_addr == CCC_ADDR_MODE)
      channel1_mode <= sfr_wdata;
    else if (wr_low)
      channel1_mode[CCC_MODE_CMP_EN] <= 1'b0;
    else if (wr_high)
      channel1_mode[CCC_MODE_CMP_EN] <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // capture/compare pair; a capture edge beats a software write in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      cmp_value <= CCC_CMP_RST;
    else if (cap_hit)
      cmp_value <= counter_value;
    else if (wr_low && !auto_reload_select)
      cmp_value[7:0] <= sfr_wdata;
    else if (wr_high && !auto_reload_select)
      cmp_value[15:8] <= sfr_wdata;
    else if (cmp_en && fn == CCC_FN_PWM && wrap && !channel1_mode[CCC_MODE_WIDE])
    begin
      // narrow pulse reloads at wrap so a new duty never glitches mid period
      if (pulse_width_select == CCC_WIDTH_8)
        cmp_value[7:0] <= cmp_value[15:8];
      else
        cmp_value <= reload;
    end
    else if (cmp_en && fn == CCC_FN_FREQ && hit)
      cmp_value[7:0] <= 8'(cmp_value[7:0] + cmp_value[15:8]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // auto-reload pair, reached through the same addresses
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      reload <= CCC_RELOAD_RST;
    else if (wr_low && auto_reload_select)
      reload[7:0] <= sfr_wdata;
    else if (wr_high && auto_reload_select)
      reload[15:8] <= sfr_wdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // output pin; nothing moves while the comparator is disabled
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      channel1_output_pin <= CCC_PIN_RST;
    else if (cmp_en)
    begin
      case (fn)
        CCC_FN_TOGGLE:
          if (hit)
            channel1_output_pin <= ~channel1_output_pin;
        CCC_FN_FREQ:
          if (hit)
            channel1_output_pin <= ~channel1_output_pin;
        CCC_FN_PWM:
          // wrap wins so a compare value of zero gives a steady high
          if (wrap)
            channel1_output_pin <= 1'b1;
          else if (hit)
            channel1_output_pin <= 1'b0;
        CCC_FN_IDLE:
          channel1_output_pin <= channel1_output_pin;
        default:
          channel1_output_pin <= channel1_output_pin;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event flag; a set in the clearing cycle wins
  assign next_flag = cap_hit
                  || (hit && cmp_en && channel1_mode[CCC_MODE_MATCH])
                  || (channel1_event_flag && !flag_clear);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      channel1_event_flag <= 1'b0;
    else
      channel1_event_flag <= next_flag;
  end

  // interrupt request follows the flag through the mask
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      flag_irq <= 1'b0;
    else
      flag_irq <= next_flag && channel1_mode[CCC_MODE_IRQ];
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads; unmapped addresses return zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      sfr_rdata <= CCC_RDATA_IDLE;
    else if (!sfr_rd)
      sfr_rdata <= CCC_RDATA_IDLE;
    else if (sfr_addr == CCC_ADDR_MODE)
      sfr_rdata <= channel1_mode;
    else if (sfr_addr == CCC_ADDR_CMP_LOW)
      sfr_rdata <= auto_reload_select ? reload[7:0] : cmp_value[7:0];
    else if (sfr_addr == CCC_ADDR_CMP_HIGH)
      sfr_rdata <= auto_reload_select ? reload[15:8] : cmp_value[15:8];
    else
      sfr_rdata <= CCC_RDATA_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence seq_capture;
    cap_hit;
  endsequence

  sequence seq_low_write;
    wr_low && !auto_reload_select && !cap_hit;
  endsequence

  // narrow pulse wrap with no capture or byte write competing for the pair
  sequence seq_narrow_wrap;
    cmp_en && fn == CCC_FN_PWM && wrap && !channel1_mode[CCC_MODE_WIDE]
      && !cap_hit && !wr_low && !wr_high;
  endsequence

  AST_LOW_WRITE_DATA: assert property (
    seq_low_write |=> cmp_value[7:0] == $past(sfr_wdata))
    else $error("low byte write not stored");
  AST_RELOAD_WRITE: assert property (
    wr_low && auto_reload_select |=> reload[7:0] == $past(sfr_wdata))
    else $error("reload low byte not written");
  AST_RELOAD_READ: assert property (
    sfr_rd && sfr_addr == CCC_ADDR_CMP_LOW && auto_reload_select
      |=> sfr_rdata == $past(reload[7:0]))
    else $error("reload low byte not read back");
  AST_LOW_CLEARS_CMP_EN: assert property (wr_low |=> !cmp_en)
    else $error("low byte write left comparator enabled");
  AST_HIGH_WRITE_DATA: assert property (
    wr_high && !auto_reload_select && !cap_hit |=> cmp_value[15:8] == $past(sfr_wdata))
    else $error("high byte write not stored");
  AST_HIGH_SETS_CMP_EN: assert property (wr_high |=> cmp_en)
    else $error("high byte write left comparator disabled");
  AST_NARROW_RELOAD: assert property (
    seq_narrow_wrap |=> cmp_value == ($past(pulse_width_select) == CCC_WIDTH_8
      ? {2{$past(cmp_value[15:8])}} : $past(reload)))
    else $error("narrow pulse wrap did not reload compare value");
  AST_DISABLED_PIN_STILL: assert property (!cmp_en |=> $stable(channel1_output_pin))
    else $error("output moved with comparator disabled");
  AST_CAPTURE_COPY: assert property (
    seq_capture |=> cmp_value == $past(counter_value) && channel1_event_flag)
    else $error("capture did not copy counter or set flag");
  AST_MATCH_FLAG: assert property (
    hit && cmp_en && channel1_mode[CCC_MODE_MATCH] |=> channel1_event_flag)
    else $error("match did not set flag");
  AST_TOGGLE_PIN: assert property (
    cmp_en && fn == CCC_FN_TOGGLE && hit |=> channel1_output_pin != $past(channel1_output_pin))
    else $error("toggle match did not invert pin");
  AST_PWM_WRAP_HIGH: assert property (
    cmp_en && fn == CCC_FN_PWM && wrap |=> channel1_output_pin)
    else $error("pulse output not high after wrap");
  AST_IRQ_MASK: assert property (
    flag_irq == (channel1_event_flag && $past(channel1_mode[CCC_MODE_IRQ])))
    else $error("interrupt request disagrees with flag and mask");

endmodule

// File: verif/ccc_pin_partner.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// far side of the channel: a source for the capture input and a meter on the
// output pin; it never answers wrongly, it only shows levels and counts
module ccc_pin_partner
(
  input  wire logic        core_clk,    // core clock
  input  wire logic        drive_level, // level the source should show
  input  wire logic        meter_en,    // count while high
  input  wire logic        meter_clr,   // zero the meter
  input  wire logic        chan_out,    // channel output pin
  output logic             capture_pin, // source output
  output logic      [15:0] out_high,    // cycles seen high
  output logic      [15:0] out_edges    // level changes seen
);
  logic last_out; // pin level one edge ago

  initial capture_pin = 1'b0;

  // source lags the edge by 3 ns, so it is really asynchronous to the core
  always @(posedge core_clk) capture_pin <= #3 drive_level;

  // meter: high time and edge count over a window the bench opens
  always @(posedge core_clk)
  begin
    last_out <= chan_out;
    if (meter_clr)
    begin
      out_high  <= 16'h0000;
      out_edges <= 16'h0000;
    end
    else if (meter_en)
    begin
      out_high  <= out_high + {15'h0000, chan_out};
      out_edges <= out_edges + {15'h0000, chan_out ^ last_out};
    end
  end
endmodule

// File: verif/ccc_channel_tb_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ccc_channel_tb_top;
  import ccc_pkg::*;

  logic        core_clk = 1'b0;    // 100 MHz
  logic        rst_b = 1'b0;       // active low
  logic [7:0]  sfr_addr = 8'h00;   // register bus
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        ars = 1'b0;         // auto-reload select
  logic [1:0]  pws = 2'h0;         // narrow width select
  logic [15:0] cnt = 16'h0000;     // counter value
  logic        tick = 1'b0;        // counter advanced
  logic        flag_clear = 1'b0;
  logic        flag, irq, pin, cap_pin, src_lvl = 1'b0;
  logic [7:0]  mode;
  logic        m_en = 1'b0;        // meter window
  logic        m_clr = 1'b0;
  logic [15:0] m_high, m_edges;
  logic        rd_d = 1'b0;        // read answer due this cycle
  logic [7:0]  exp_q[$];           // expected read data, oldest first
  logic [7:0]  d0, d1;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #5 core_clk = ~core_clk;

  ccc_channel uut (.core_clk(core_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .auto_reload_select(ars),
    .pulse_width_select(pws), .counter_value(cnt), .count_tick(tick), .capture_pin(cap_pin),
    .flag_clear(flag_clear), .channel1_event_flag(flag), .flag_irq(irq),
    .channel1_output_pin(pin), .channel1_mode(mode));

  ccc_pin_partner pm (.core_clk(core_clk), .drive_level(src_lvl), .meter_en(m_en),
    .meter_clr(m_clr), .chan_out(pin), .capture_pin(cap_pin), .out_high(m_high),
    .out_edges(m_edges));

  ////////////////////////////////////////////////////////////////////////////////
  // comparison, shared by every check
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read answers stand one cycle, so they are taken mid-cycle after the strobe
  always @(posedge core_clk) rd_d <= sfr_rd;
  always @(negedge core_clk)
  begin
    if (rd_d)
      chk("read data", {8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()});
  end

  // hang guard: the whole run needs about 2200 cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: strobe held one edge, a free edge between accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    sfr_rd <= 1'b0;
  endtask

  // counter advances every cycle from start; tick is left high for the caller
  task automatic run(input logic [15:0] start, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      cnt <= start + i[15:0];
      tick <= 1'b1;
    end
  endtask

  task automatic stop_and_settle();
    @(posedge core_clk);
    tick <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // clear the meter during one period, then measure the next 256 counts
  task automatic measure();
    m_clr <= 1'b1;
    run(16'h0000, 256);
    m_clr <= 1'b0;
    m_en <= 1'b1;
    run(16'h0100, 256);
    m_en <= 1'b0;
    stop_and_settle();
  endtask

  task automatic wait_flag(input logic e);
    for (int i = 0; i < 8 && flag !== e; i++) @(negedge core_clk);
  endtask

  task automatic clr_flag();
    @(posedge core_clk);
    flag_clear <= 1'b1;
    @(posedge core_clk);
    flag_clear <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(54997));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values, unmapped place
    rd(CCC_ADDR_MODE, 8'h00);
    rd(CCC_ADDR_CMP_LOW, 8'h00);
    rd(CCC_ADDR_CMP_HIGH, 8'h00);
    rd(8'h55, CCC_RDATA_IDLE);
    $display("reset test done");
    // byte access and the comparator enable side effects
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    wr(CCC_ADDR_CMP_HIGH, d1);
    @(negedge core_clk);
    chk("enable after high", {15'h0000, mode[CCC_MODE_CMP_EN]}, 16'h0001);
    wr(CCC_ADDR_CMP_LOW, d0);
    @(negedge core_clk);
    chk("enable after low", {15'h0000, mode[CCC_MODE_CMP_EN]}, 16'h0000);
    rd(CCC_ADDR_CMP_LOW, d0);
    rd(CCC_ADDR_CMP_HIGH, d1);
    // reload pair behind the same addresses
    ars <= 1'b1;
    wr(CCC_ADDR_CMP_LOW, ~d0);
    wr(CCC_ADDR_CMP_HIGH, ~d1);
    rd(CCC_ADDR_CMP_LOW, ~d0);
    rd(CCC_ADDR_CMP_HIGH, ~d1);
    ars <= 1'b0;
    rd(CCC_ADDR_CMP_LOW, d0);
    rd(CCC_ADDR_CMP_HIGH, d1);
    wr(CCC_ADDR_MODE, d0);
    rd(CCC_ADDR_MODE, d0);
    $display("register test done");
    // rising capture with interrupt passed on, then falling only, masked
    cnt <= 16'($urandom);
    wr(CCC_ADDR_MODE, 8'h21);
    src_lvl <= 1'b1;
    wait_flag(1'b1);
    chk("rise flag", {15'h0000, flag}, 16'h0001);
    chk("rise irq", {15'h0000, irq}, 16'h0001);
    rd(CCC_ADDR_CMP_LOW, cnt[7:0]);
    rd(CCC_ADDR_CMP_HIGH, cnt[15:8]);
    clr_flag();
    wr(CCC_ADDR_MODE, 8'h10);
    src_lvl <= 1'b0;
    wait_flag(1'b1);
    chk("fall flag", {15'h0000, flag}, 16'h0001);
    chk("masked irq", {15'h0000, irq}, 16'h0000);
    clr_flag();
    src_lvl <= 1'b1;
    repeat (8) @(negedge core_clk);
    chk("rise ignored", {15'h0000, flag}, 16'h0000);
    $display("capture test done");
    // match flag gated by the comparator enable
    wr(CCC_ADDR_CMP_LOW, 8'h23);
    wr(CCC_ADDR_CMP_HIGH, 8'h01);
    // match and toggle asked for with the comparator off: neither may act
    wr(CCC_ADDR_MODE, 8'h0C);
    d1 = {7'h00, pin};
    run(16'h0120, 8);
    stop_and_settle();
    chk("match disabled", {15'h0000, flag}, 16'h0000);
    chk("disabled pin", {15'h0000, pin}, {15'h0000, d1[0]});
    wr(CCC_ADDR_MODE, 8'h48);
    run(16'h0120, 8);
    stop_and_settle();
    chk("match flag", {15'h0000, flag}, 16'h0001);
    clr_flag();
    // toggle: one inversion per pass over the compare value
    wr(CCC_ADDR_MODE, 8'h44);
    d0 = {7'h00, pin};
    for (int k = 1; k <= 2; k++)
    begin
      run(16'h0120, 8);
      stop_and_settle();
      chk("toggle pin", {15'h0000, pin}, {15'h0000, d0[0] ^ k[0]});
    end
    $display("match test done");
    // 8-bit pulse: high from wrap to the compare value
    wr(CCC_ADDR_CMP_LOW, 8'h40);
    wr(CCC_ADDR_CMP_HIGH, 8'h40);
    wr(CCC_ADDR_MODE, 8'h42);
    measure();
    chk("pulse high time", m_high, 16'h0040);
    // wide select: counts 0x100..0x1FF neither wrap 16 bits nor hit 0x4040
    wr(CCC_ADDR_MODE, 8'hC2);
    measure();
    chk("wide pulse edges", m_edges, 16'h0000);
    // frequency output: step 0x20 from 0x10 gives 8 toggles per 256 counts
    wr(CCC_ADDR_CMP_LOW, 8'h10);
    wr(CCC_ADDR_CMP_HIGH, 8'h20);
    wr(CCC_ADDR_MODE, 8'h46);
    measure();
    chk("frequency edges", m_edges, 16'h0008);
    // 9-bit pulse: wrap at 0 loads reload 0x0180, so high over counts 0xFE..0x17F
    @(posedge core_clk);
    ars <= 1'b1;
    pws <= 2'h1;
    wr(CCC_ADDR_CMP_LOW, 8'h80);
    wr(CCC_ADDR_CMP_HIGH, 8'h01);
    ars <= 1'b0;
    wr(CCC_ADDR_MODE, 8'h42);
    measure();
    chk("narrow pulse high time", m_high, 16'h0082);
    $display("output test done");
    repeat (2) @(posedge core_clk);
    final_report();
  end
endmodule
